// file: rtl/lcdc_cmd.sv
// command decoder, display ram and settings of the lcd controller
// Behaviour
// - data byte write stores at current page/column, then column plus one
// - data read returns byte at page/column, then column plus one
// - after a column set the first read is a dummy, discard it
// - serial interface mode gives no display ram read-back
// - segment map command: low bit clear keeps order, set mirrors it
// - column increment always follows native ram order
// - A6 lights ram ones, A7 lights ram zeros, ram untouched
// - A5 forces all points on over inverse, A4 restores, ram kept
// - all points on while display off enters power save
// - A2/A3 pick the lower or higher bias for the duty
// - E0 enters read/modify/write: reads hold column, writes step it
// - column saved on E0, restored and mode left on EE
// - all other commands still run during read/modify/write
// - E2 resets line, column, page, com direction, leaves rmw, keeps ram
// - C0 scans commons upward, bit 3 set scans downward, bits 2-0 ignored
// - 28-2F: D2 booster, D1 regulator, D0 follower on when set
// - column increment stops at 83 and never carries into page
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module lcdc_cmd
  import lcdc_pkg::*;
#(
  parameter int unsigned DEPTH = lcdc_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              host_cds,
  input  wire logic              host_wr_n,
  input  wire logic              host_rd_n,
  input  wire logic              host_serial_sel,
  input  wire logic [7:0]        host_data_in,
  output logic [7:0]             host_data_out,
  output logic                   host_data_oe,
  output logic                   host_busy,
  output lcdc_pkg::lcdc_disp_s   disp
);
  import lcdc_pkg::*;

  initial begin
    if (DEPTH < 2) $error("queue depth too small");
  end

  lcdc_pins_s  s1_reg, s2_reg, s3_reg;
  lcdc_op_s    push_op, pop_op, op_reg, op_next;
  lcdc_state_e st_reg, st_next;
  lcdc_disp_s  dsp_reg, dsp_next;
  logic [7:0]  latch_reg, latch_next;
  logic [7:0]  saved_reg, saved_next;
  logic [7:0]  dout_reg;
  logic        oe_reg, busy_reg;
  logic        push_v, push_rdy, pop_v, pop_rdy;
  logic        wr_rise, rd_rise;
  logic        ram_we;
  logic        addr_ok;
  logic [7:0]  ram_q;
  logic        exec_cmd, exec_wr, exec_rd;
  logic [7:0]  col_step;

  // display ram, one byte per page and column
  logic [7:0]  ram [PAGES][COLS];

  // pin synchroniser, stage three feeds the edge detect and the queued transfer fields
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= {host_serial_sel, host_wr_n, host_rd_n, host_cds, host_data_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a transfer is taken when its strobe is released
  assign wr_rise = s2_reg.wr_n & ~s3_reg.wr_n;
  assign rd_rise = s2_reg.rd_n & ~s3_reg.rd_n;

  // data reads are queued only in parallel mode
  always_comb begin
    push_op.is_read = rd_rise;
    push_op.cds     = s3_reg.cds;
    push_op.data    = s3_reg.data;
    push_v          = wr_rise | (rd_rise & s3_reg.cds & ~s3_reg.serial_sel);
  end

  lcdc_fifo #(
    .WIDTH ($bits(lcdc_op_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_v),
    .in_ready  (push_rdy),
    .in_data   (push_op),
    .out_valid (pop_v),
    .out_ready (pop_rdy),
    .out_data  (pop_op)
  );

  // decoder takes one entry every other cycle, so the queue can fill
  assign pop_rdy  = (st_reg == ST_FETCH);
  assign exec_cmd = (st_reg == ST_EXEC) & ~op_reg.is_read & ~op_reg.cds;
  assign exec_wr  = (st_reg == ST_EXEC) & ~op_reg.is_read & op_reg.cds;
  assign exec_rd  = (st_reg == ST_EXEC) & op_reg.is_read;

  // ram port, out-of-range addresses read zero and never write
  assign addr_ok = (dsp_reg.page < 4'(PAGES)) & (dsp_reg.column <= COL_LAST);
  assign ram_q   = addr_ok ? ram[dsp_reg.page][dsp_reg.column] : 8'h00;
  assign ram_we  = exec_wr & addr_ok;

  // saturating step, native order regardless of segment mapping
  assign col_step = (dsp_reg.column < COL_LAST) ? dsp_reg.column + 8'h01 : dsp_reg.column;

  // decoder state, settings, read latch and saved column
  always_comb begin
    st_next    = st_reg;
    op_next    = op_reg;
    dsp_next   = dsp_reg;
    latch_next = latch_reg;
    saved_next = saved_reg;
    case (st_reg)
      ST_FETCH: begin
        if (pop_v) begin
          op_next = pop_op;
          st_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        st_next = ST_FETCH;
        if (op_reg.is_read) begin
          // latch refills here, so the first read after a set is stale
          latch_next = ram_q;
          if (!dsp_reg.rmw_active) begin
            dsp_next.column = col_step;
          end
        end else if (op_reg.cds) begin
          dsp_next.column = col_step;
        end else begin
          // every command stays legal inside read/modify/write
          case (op_reg.data)
            CMD_SEG_NORM: dsp_next.seg_reverse = 1'b0;
            CMD_SEG_REV:  dsp_next.seg_reverse = 1'b1;
            CMD_BIAS_LO:  dsp_next.bias_high   = 1'b0;
            CMD_BIAS_HI:  dsp_next.bias_high   = 1'b1;
            CMD_ALL_OFF:  dsp_next.all_on      = 1'b0;
            CMD_ALL_ON:   dsp_next.all_on      = 1'b1;
            CMD_INV_OFF:  dsp_next.inverse     = 1'b0;
            CMD_INV_ON:   dsp_next.inverse     = 1'b1;
            CMD_DISP_OFF: dsp_next.display_on  = 1'b0;
            CMD_DISP_ON:  dsp_next.display_on  = 1'b1;
            CMD_RMW: begin
              dsp_next.rmw_active = 1'b1;
              saved_next          = dsp_reg.column;
            end
            CMD_END: begin
              if (dsp_reg.rmw_active) begin
                dsp_next.column = saved_reg;
              end
              dsp_next.rmw_active = 1'b0;
            end
            CMD_RESET: begin
              // ram and display/power flags are left alone
              dsp_next.start_line  = LINE_RST;
              dsp_next.column      = COL_RST;
              dsp_next.page        = PAGE_RST;
              dsp_next.com_reverse = 1'b0;
              dsp_next.rmw_active  = 1'b0;
            end
            default: begin
              if ((op_reg.data & MASK_NIB) == GRP_COM) begin
                dsp_next.com_reverse = op_reg.data[BIT_COM_DIR];
              end else if ((op_reg.data & MASK_PWR) == GRP_PWR) begin
                dsp_next.booster_en   = op_reg.data[BIT_BOOST];
                dsp_next.regulator_en = op_reg.data[BIT_REGUL];
                dsp_next.follower_en  = op_reg.data[BIT_FOLLOW];
              end else if ((op_reg.data & MASK_NIB) == GRP_PAGE) begin
                dsp_next.page = op_reg.data[3:0];
              end else if ((op_reg.data & MASK_NIB) == GRP_COL_HI) begin
                dsp_next.column = {op_reg.data[3:0], dsp_reg.column[3:0]};
              end else if ((op_reg.data & MASK_NIB) == GRP_COL_LO) begin
                dsp_next.column = {dsp_reg.column[7:4], op_reg.data[3:0]};
              end else if ((op_reg.data & MASK_LINE) == GRP_LINE) begin
                dsp_next.start_line = op_reg.data[5:0];
              end
            end
          endcase
        end
      end
      default: begin
        st_next = ST_FETCH;
      end
    endcase
    // power save follows the display and all-on flags together
    dsp_next.power_save = dsp_next.all_on & ~dsp_next.display_on;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg    <= ST_FETCH;
      op_reg    <= '0;
      dsp_reg   <= DISP_RST;
      latch_reg <= LATCH_RST;
      saved_reg <= COL_RST;
    end else begin
      st_reg    <= st_next;
      op_reg    <= op_next;
      dsp_reg   <= dsp_next;
      latch_reg <= latch_next;
      saved_reg <= saved_next;
    end
  end

  // ram write, no reset so contents survive the reset command
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram[dsp_reg.page][dsp_reg.column] <= op_reg.data;
    end
  end

  // host read drive: latch content while a parallel data read is low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dout_reg <= LATCH_RST;
      oe_reg   <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      dout_reg <= latch_reg;
      oe_reg   <= ~s2_reg.rd_n & s2_reg.cds & ~s2_reg.serial_sel;
      busy_reg <= ~push_rdy;
    end
  end

  assign host_data_out = dout_reg;
  assign host_data_oe  = oe_reg;
  assign host_busy     = busy_reg;
  assign disp          = dsp_reg;

  // checks on the decoder

  a_col_write_step: assert property (@(posedge clk) disable iff (sys_rst)
    exec_wr && dsp_reg.column < COL_LAST |=> dsp_reg.column == $past(dsp_reg.column) + 8'h01)
    else $error("column did not step after data write");

  a_col_top_stop: assert property (@(posedge clk) disable iff (sys_rst)
    (exec_wr || (exec_rd && !dsp_reg.rmw_active)) && dsp_reg.column == COL_LAST
    |=> dsp_reg.column == COL_LAST && $stable(dsp_reg.page))
    else $error("column moved past its top or page changed");

  a_rmw_read_hold: assert property (@(posedge clk) disable iff (sys_rst)
    exec_rd && dsp_reg.rmw_active |=> $stable(dsp_reg.column))
    else $error("read in rmw mode moved the column");

  // any end inside the mode must bring back the saved column
  a_end_col_restore: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && op_reg.data == CMD_END && dsp_reg.rmw_active
    |=> dsp_reg.column == $past(saved_reg) && !dsp_reg.rmw_active)
    else $error("end did not restore the saved column");

  a_rmw_save_col: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && op_reg.data == CMD_RMW
    |=> saved_reg == $past(dsp_reg.column) && dsp_reg.rmw_active)
    else $error("column not saved on entering rmw");

  a_serial_no_read: assert property (@(posedge clk) disable iff (sys_rst)
    s2_reg.serial_sel |=> !host_data_oe)
    else $error("read drive enabled in serial mode");

  a_oe_parallel: assert property (@(posedge clk) disable iff (sys_rst)
    !s2_reg.rd_n && s2_reg.cds && !s2_reg.serial_sel |=> host_data_oe)
    else $error("read drive missing on parallel data read");

  a_psave_tie: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && op_reg.data == CMD_ALL_ON && !dsp_reg.display_on |=> dsp_reg.power_save && dsp_reg.all_on)
    else $error("power save not entered");

  a_reset_cmd_init: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && op_reg.data == CMD_RESET
    |=> dsp_reg.column == COL_RST && dsp_reg.page == PAGE_RST && !dsp_reg.rmw_active && !dsp_reg.com_reverse)
    else $error("reset command left state set");

  a_pwr_bits: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data & MASK_PWR) == GRP_PWR
    |=> {dsp_reg.booster_en, dsp_reg.regulator_en, dsp_reg.follower_en} == $past(op_reg.data[2:0]))
    else $error("power enables differ from command bits");

  a_seg_dir: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data == CMD_SEG_NORM || op_reg.data == CMD_SEG_REV)
    |=> dsp_reg.seg_reverse == $past(op_reg.data[0]))
    else $error("segment direction not taken");

  a_com_dir: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data & MASK_NIB) == GRP_COM |=> dsp_reg.com_reverse == $past(op_reg.data[3]))
    else $error("common direction not taken");

  a_inv_flag: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data == CMD_INV_ON || op_reg.data == CMD_INV_OFF)
    |=> dsp_reg.inverse == $past(op_reg.data[0]) && $stable(dsp_reg.column))
    else $error("inverse flag not taken");

  a_all_on_flag: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data == CMD_ALL_ON || op_reg.data == CMD_ALL_OFF)
    |=> dsp_reg.all_on == $past(op_reg.data[0]) && $stable(dsp_reg.column))
    else $error("all points flag not taken");

  a_bias_flag: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data == CMD_BIAS_LO || op_reg.data == CMD_BIAS_HI)
    |=> dsp_reg.bias_high == $past(op_reg.data[0]))
    else $error("bias select not taken");

  // a command inside read/modify/write runs and keeps the mode
  a_rmw_cmd_run: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && dsp_reg.rmw_active && (op_reg.data == CMD_INV_ON || op_reg.data == CMD_INV_OFF)
    |=> dsp_reg.rmw_active && dsp_reg.inverse == $past(op_reg.data[0]))
    else $error("command ignored in rmw mode");

  // data bytes must never reach the command decode
  a_data_not_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    exec_wr |=> $stable(dsp_reg.seg_reverse) && $stable(dsp_reg.inverse) && $stable(dsp_reg.display_on))
    else $error("data byte changed a display setting");

  a_ram_write_data: assert property (@(posedge clk) disable iff (sys_rst)
    exec_wr && addr_ok |=> ram[$past(dsp_reg.page)][$past(dsp_reg.column)] == $past(op_reg.data))
    else $error("data byte not stored in ram");

  a_col_read_step: assert property (@(posedge clk) disable iff (sys_rst)
    exec_rd && !dsp_reg.rmw_active && dsp_reg.column < COL_LAST
    |=> dsp_reg.column == $past(dsp_reg.column) + 8'h01)
    else $error("column did not step after data read");

  a_page_set: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data & MASK_NIB) == GRP_PAGE |=> dsp_reg.page == $past(op_reg.data[3:0]))
    else $error("page address not taken");

  a_line_set: assert property (@(posedge clk) disable iff (sys_rst)
    exec_cmd && (op_reg.data & MASK_LINE) == GRP_LINE |=> dsp_reg.start_line == $past(op_reg.data[5:0]))
    else $error("start line not taken");

  a_read_latch: assert property (@(posedge clk) disable iff (sys_rst)
    exec_rd |=> latch_reg == $past(ram_q))
    else $error("read latch not refilled from ram");
endmodule // lcdc_cmd

// file: rtl/lcdc_fifo.sv
// synchronous fifo between host capture and the command decoder
`timescale 1ns/100ps
module lcdc_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  // full and empty come straight from the count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count updates
  always_comb begin
    wr_next  = push ? wr_reg + AW'(1) : wr_reg;
    rd_next  = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset, contents are only read when counted valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule // lcdc_fifo

// file: rtl/lcdc_pkg.sv
// package for the lcd controller command decoder: codes, layouts, types
package lcdc_pkg;
  // display ram geometry
  localparam int unsigned   PAGES      = 9;
  localparam int unsigned   COLS       = 132;
  localparam logic [7:0]    COL_LAST   = 8'h83;
  localparam logic [7:0]    COL_RST    = 8'h00;
  localparam logic [3:0]    PAGE_RST   = 4'h0;
  localparam logic [5:0]    LINE_RST   = 6'h00;
  localparam logic [7:0]    LATCH_RST  = 8'h00;
  localparam int unsigned   FIFO_DEPTH = 32;
  // single byte commands
  localparam logic [7:0]    CMD_SEG_NORM = 8'hA0;
  localparam logic [7:0]    CMD_SEG_REV  = 8'hA1;
  localparam logic [7:0]    CMD_BIAS_LO  = 8'hA2;
  localparam logic [7:0]    CMD_BIAS_HI  = 8'hA3;
  localparam logic [7:0]    CMD_ALL_OFF  = 8'hA4;
  localparam logic [7:0]    CMD_ALL_ON   = 8'hA5;
  localparam logic [7:0]    CMD_INV_OFF  = 8'hA6;
  localparam logic [7:0]    CMD_INV_ON   = 8'hA7;
  localparam logic [7:0]    CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0]    CMD_DISP_ON  = 8'hAF;
  localparam logic [7:0]    CMD_RMW      = 8'hE0;
  localparam logic [7:0]    CMD_END      = 8'hEE;
  localparam logic [7:0]    CMD_RESET    = 8'hE2;
  // command groups with an operand field
  localparam logic [7:0]    MASK_NIB    = 8'hF0;
  localparam logic [7:0]    MASK_PWR    = 8'hF8;
  localparam logic [7:0]    MASK_LINE   = 8'hC0;
  localparam logic [7:0]    GRP_COM     = 8'hC0;
  localparam logic [7:0]    GRP_PWR     = 8'h28;
  localparam logic [7:0]    GRP_PAGE    = 8'hB0;
  localparam logic [7:0]    GRP_COL_HI  = 8'h10;
  localparam logic [7:0]    GRP_COL_LO  = 8'h00;
  localparam logic [7:0]    GRP_LINE    = 8'h40;
  localparam int unsigned   BIT_COM_DIR = 3;
  localparam int unsigned   BIT_BOOST   = 2;
  localparam int unsigned   BIT_REGUL   = 1;
  localparam int unsigned   BIT_FOLLOW  = 0;

  // one queued host transfer
  typedef struct packed {
    logic       is_read;
    logic       cds;
    logic [7:0] data;
  } lcdc_op_s;

  // host pins after synchronisation
  typedef struct packed {
    logic       serial_sel;
    logic       wr_n;
    logic       rd_n;
    logic       cds;
    logic [7:0] data;
  } lcdc_pins_s;

  // display and power settings shown to the panel logic
  typedef struct packed {
    logic       display_on;
    logic       seg_reverse;
    logic       inverse;
    logic       all_on;
    logic       bias_high;
    logic       com_reverse;
    logic       booster_en;
    logic       regulator_en;
    logic       follower_en;
    logic       power_save;
    logic       rmw_active;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] column;
  } lcdc_disp_s;

  localparam lcdc_disp_s DISP_RST = '0;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } lcdc_state_e;
endpackage

// file: verification/lcdc_host_model.sv
// host microprocessor model driving the parallel pins of the command decoder
`timescale 1ns/100ps
module lcdc_host_model (
  input  wire logic       clk,
  output logic            host_cds,
  output logic            host_wr_n,
  output logic            host_rd_n,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe
);
  // idle at time zero: strobes inactive, undriven bus shown as a pattern
  initial begin
    host_cds     = 1'b0;
    host_wr_n    = 1'b1;
    host_rd_n    = 1'b1;
    host_data_in = 8'hA5;
  end

  // one transfer: strobe low five clocks, sample, release, rest nine clocks for sync and decode
  task automatic xfer(input logic cds, input logic is_rd, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
    @(posedge clk);
    host_cds <= cds;
    if (is_rd) begin
      host_rd_n    <= 1'b0;
      host_data_in <= ~host_data_in; // host leaves the bus on reads
    end else begin
      host_wr_n    <= 1'b0;
      host_data_in <= d;
    end
    repeat (5) @(posedge clk);
    q         = host_data_out;
    oe        = host_data_oe;
    host_rd_n <= 1'b1;
    host_wr_n <= 1'b1;
    @(posedge clk);
    host_data_in <= ~host_data_in; // hold time over, byte no longer shown
    repeat (8) @(posedge clk);
  endtask
endmodule // lcdc_host_model

// file: verification/tb_top.sv
// testbench top: host model exercises the command decoder through its pins
`timescale 1ns/100ps
module tb_top;
  import lcdc_pkg::*;
  logic        clk;
  logic        sys_rst;
  logic        host_cds;
  logic        host_wr_n;
  logic        host_rd_n;
  logic        host_serial_sel;
  logic [7:0]  host_data_in;
  logic [7:0]  host_data_out;
  logic        host_data_oe;
  logic        host_busy;
  lcdc_disp_s  disp;
  int          fail_count;
  int          tests_run;
  int          cycles;
  logic [7:0]  q;
  logic        oe;
  // flag order: on, segrev, inv, allon, bias, comrev, boost, reg, follow, psave, rmw
  logic [7:0]  cmds [17] = '{8'hA1, 8'hA0, 8'hA7, 8'hA3, 8'hA5, 8'hAF, 8'hA4, 8'hA6, 8'hA2,
                             8'hCF, 8'hC7, 8'h2C, 8'h2A, 8'h29, 8'h2F, 8'h28, 8'hAE};
  logic [10:0] exps [17] = '{11'h200, 11'h000, 11'h100, 11'h140, 11'h1C2, 11'h5C0, 11'h540,
                             11'h440, 11'h400, 11'h420, 11'h400, 11'h410, 11'h408, 11'h404,
                             11'h41C, 11'h400, 11'h000};

  lcdc_cmd #(.DEPTH(4)) dut (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .host_cds        (host_cds),
    .host_wr_n       (host_wr_n),
    .host_rd_n       (host_rd_n),
    .host_serial_sel (host_serial_sel),
    .host_data_in    (host_data_in),
    .host_data_out   (host_data_out),
    .host_data_oe    (host_data_oe),
    .host_busy       (host_busy),
    .disp            (disp)
  );

  lcdc_host_model u_host (
    .clk           (clk),
    .host_cds      (host_cds),
    .host_wr_n     (host_wr_n),
    .host_rd_n     (host_rd_n),
    .host_data_in  (host_data_in),
    .host_data_out (host_data_out),
    .host_data_oe  (host_data_oe)
  );

  // free running clock
  always #5 clk = ~clk;

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // single comparison point, four-state equality
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] d);
    u_host.xfer(1'b0, 1'b0, d, q, oe);
  endtask

  task automatic dat(input logic [7:0] d);
    u_host.xfer(1'b1, 1'b0, d, q, oe);
  endtask

  task automatic rd();
    u_host.xfer(1'b1, 1'b1, 8'h00, q, oe);
  endtask

  task automatic test_done();
    $display("tests run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk             = 1'b0;
    sys_rst         = 1'b1;
    host_serial_sel = 1'b0;
    fail_count      = 0;
    tests_run       = 0;
    cycles          = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("disp reset", 32'(DISP_RST), 32'(disp));
    chk("oe reset", 32'h0, 32'(host_data_oe));
    $display("test reset done");
    // settings table, cumulative from reset
    for (int i = 0; i < 17; i++) begin
      cmd(cmds[i]);
      chk("flags", 32'(exps[i]), 32'(disp[28:18]));
    end
    $display("test settings done");
    // writes then reads with mirrored segments; stepping stays native
    cmd(8'hA1);
    cmd(8'hB2);
    cmd(8'h10);
    cmd(8'h05);
    dat(8'h3C);
    dat(8'hC3);
    dat(8'h96);
    chk("column", 32'h08, 32'(disp.column));
    chk("page", 32'h2, 32'(disp.page));
    cmd(8'h10);
    cmd(8'h05);
    rd();
    rd();
    chk("read a", 32'h3C, 32'(q));
    chk("oe", 32'h1, 32'(oe));
    rd();
    chk("read b", 32'hC3, 32'(q));
    $display("test data access done");
    // read/modify/write: reads hold, writes step, end restores
    cmd(8'h10);
    cmd(8'h05);
    cmd(8'hE0);
    chk("rmw on", 32'h1, 32'(disp.rmw_active));
    rd();
    rd();
    chk("rmw read", 32'h3C, 32'(q));
    chk("rmw col", 32'h05, 32'(disp.column));
    dat(8'h5A);
    chk("rmw wcol", 32'h06, 32'(disp.column));
    cmd(8'hA7);
    chk("rmw inv", 32'h1, 32'(disp.inverse));
    cmd(8'hEE);
    chk("end col", 32'h05, 32'(disp.column));
    chk("end rmw", 32'h0, 32'(disp.rmw_active));
    $display("test rmw done");
    // column stops at the last column, page never carries
    cmd(8'h18);
    cmd(8'h03);
    dat(8'h11);
    dat(8'h22);
    chk("col top", 32'h83, 32'(disp.column));
    chk("page kept", 32'h2, 32'(disp.page));
    $display("test column limit done");
    // software reset clears addressing and modes, keeps ram
    cmd(8'h45);
    cmd(8'hC8);
    cmd(8'hE0);
    cmd(8'hE2);
    chk("rst flags", 32'h0, 32'({disp.start_line, disp.page, disp.column}));
    chk("rst modes", 32'h0, 32'({disp.com_reverse, disp.rmw_active}));
    cmd(8'hB2);
    cmd(8'h10);
    cmd(8'h05);
    rd();
    rd();
    chk("ram kept", 32'h5A, 32'(q));
    $display("test reset command done");
    // serial mode: no read-back, writes still step
    host_serial_sel <= 1'b1;
    repeat (4) @(posedge clk);
    rd();
    chk("serial oe", 32'h0, 32'(oe));
    dat(8'h77);
    chk("serial col", 32'h08, 32'(disp.column));
    host_serial_sel <= 1'b0;
    chk("busy", 32'h0, 32'(host_busy));
    $display("test serial done");
    test_done();
  end
endmodule // tb_top
